// ===== design/apsm_monitor.sv
// Peak signal monitor: magnitude tracker, window timer, registers, buffer and link serializer
`timescale 1ns/1ns
// Overview of operation
// [RULE1] Track sample magnitude only, 13-bit unsigned
// [RULE2] Window length is 24-bit sample count
// [RULE3] Control register bit 1 enables detection
// [RULE4] Software writes window before enabling detection
// [RULE5] Enable loads timer, counts down each clock
// [RULE6] Keep larger of input and hidden peak
// [RULE7] Detection start seeds peak with current sample
// [RULE8] At timer one, copy peak to holding
// [RULE9] Then reload timer and continue without pause
// [RULE10] First sample of window overwrites stored peak
// [RULE11] Holding value readable and sent on link
// [RULE12] Link channel needs both enable fields set
// [RULE13] Control bits filled from MSB, one used
// [RULE14] Monitor stream uses MSB control bit
// [RULE15] Software programs link output selection registers
// [RULE16] 25-bit frame, MSB first, five subframes
// [RULE17] Receiver reassembles frames using start bits
// [RULE18] Idle ones, ID subframe, then data subframes

// ************************************************************
// Peak buffer FIFO
// ************************************************************
module apsm_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage array
  logic [AW:0]      wp_ff;           // Write pointer with wrap bit
  logic [AW:0]      rp_ff;           // Read pointer with wrap bit
  logic             push;
  logic             pop;
  assign in_ready  = (wp_ff ^ rp_ff) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_ff != rp_ff;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rp_ff[AW-1:0]];
  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end
  // Pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + (AW+1)'(1);
      if (pop)  rp_ff <= rp_ff + (AW+1)'(1);
    end
  end
endmodule

// ************************************************************
// Monitor top
// ************************************************************
module apsm_monitor
  import apsm_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic                link_sample_strobe,
  output logic      [2:0]          link_ctrl_bits,
  output logic                     peak_fifo_ready,
  output logic      [12:0]         peak_holding
);
  initial begin
    if (SAMPLE_W < 14) $error("SAMPLE_W must be at least 14");
  end
  // All checks below sample on the sample clock and sleep during reset
  default clocking dflt_cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]  ctrl_ff;          // Monitor control
  logic [23:0] win_ff;           // Window length setting
  logic [7:0]  lena_ff;          // Link enable a
  logic [7:0]  lenb_ff;          // Link enable b
  logic [7:0]  sela_ff;          // Control bit select a
  logic [7:0]  selb_ff;          // Control bit select b
  logic [7:0]  csps_ff;          // Control bits per sample
  logic [12:0] hold_ff;          // Peak holding
  logic [7:0]  rdata_ff;         // Read data
  logic        rvalid_ff;        // Read answer strobe
  logic [7:0]  nxt_rdata;

  // Register writes; software owns ordering of window before enable [RULE4] [RULE15]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= RST_BYTE;
      win_ff  <= RST_WIN;
      lena_ff <= RST_BYTE;
      lenb_ff <= RST_BYTE;
      sela_ff <= RST_BYTE;
      selb_ff <= RST_BYTE;
      csps_ff <= RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: ctrl_ff        <= reg_wdata;  // [RULE3]
        ADDR_WIN0: win_ff[7:0]    <= reg_wdata;  // [RULE2]
        ADDR_WIN1: win_ff[15:8]   <= reg_wdata;  // [RULE2]
        ADDR_WIN2: win_ff[23:16]  <= reg_wdata;  // [RULE2]
        ADDR_LENA: lena_ff        <= reg_wdata;
        ADDR_LENB: lenb_ff        <= reg_wdata;
        ADDR_SELA: sela_ff        <= reg_wdata;
        ADDR_SELB: selb_ff        <= reg_wdata;
        ADDR_CSPS: csps_ff        <= reg_wdata;
        default: ;                                // Unmapped writes ignored
      endcase
    end
  end

  // Read decode; holding register is visible, stored peak is not [RULE11] [RULE6]
  always_comb begin
    case (reg_addr)
      ADDR_CTRL:  nxt_rdata = ctrl_ff;
      ADDR_WIN0:  nxt_rdata = win_ff[7:0];
      ADDR_WIN1:  nxt_rdata = win_ff[15:8];
      ADDR_WIN2:  nxt_rdata = win_ff[23:16];
      ADDR_PEAK0: nxt_rdata = hold_ff[7:0];
      ADDR_PEAK1: nxt_rdata = {3'h0, hold_ff[12:8]};
      ADDR_LENA:  nxt_rdata = lena_ff;
      ADDR_LENB:  nxt_rdata = lenb_ff;
      ADDR_SELA:  nxt_rdata = sela_ff;
      ADDR_SELB:  nxt_rdata = selb_ff;
      ADDR_CSPS:  nxt_rdata = csps_ff;
      default:    nxt_rdata = 8'h00;               // Unmapped reads zero
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata    = rdata_ff;
  assign reg_rvalid   = rvalid_ff;
  assign peak_holding = hold_ff;

  // ************************************************************
  // Magnitude, timer and peak tracking
  // ************************************************************
  logic                en;                 // Peak detect enabled
  logic                en_d_ff;            // Enable of last cycle
  logic [23:0]         timer_ff;           // Period timer
  logic                first_ff;           // Next sample opens a window
  logic [12:0]         peak_ff;            // Hidden stored peak
  logic [SAMPLE_W-1:0] abs_w;
  logic [12:0]         mag_w;
  logic [12:0]         max_w;
  logic [23:0]         win_eff;            // Zero length acts as one
  logic                wend;               // Last sample of window

  assign en      = ctrl_ff[CTRL_PEAK_EN_BIT];                      // [RULE3]
  assign abs_w   = sample_in[SAMPLE_W-1] ? SAMPLE_W'(-sample_in) : sample_in;
  // Full scale negative overflows 13 bits, so clip rather than wrap [RULE1]
  assign mag_w   = (abs_w > SAMPLE_W'(MAG_MAX)) ? MAG_MAX : abs_w[12:0];
  assign max_w   = first_ff ? mag_w : ((mag_w > peak_ff) ? mag_w : peak_ff); // [RULE6]
  assign win_eff = (win_ff == 24'h000000) ? 24'h000001 : win_ff;
  assign wend    = en && en_d_ff && (timer_ff == 24'h000001);

  // Period timer: loaded on enable, reloaded at window end [RULE5] [RULE9]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_d_ff  <= 1'b0;
      timer_ff <= 24'h000000;
    end else begin
      en_d_ff <= en;
      if (en && !en_d_ff) begin
        timer_ff <= win_eff;               // [RULE5]
      end else if (wend) begin
        timer_ff <= win_eff;               // [RULE9]
      end else if (en) begin
        timer_ff <= timer_ff - 24'h000001; // [RULE5]
      end
    end
  end

  // Stored peak and window start flag [RULE7] [RULE10]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_ff <= 1'b1;
      peak_ff  <= 13'h0000;
    end else begin
      if (!en) begin
        first_ff <= 1'b1;                  // Sample of the second enabled cycle seeds [RULE7]
      end else if (en_d_ff) begin
        peak_ff  <= max_w;                 // [RULE6]
        first_ff <= wend;                  // [RULE10]
      end
    end
  end
  // Holding register captures the window result [RULE8]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_ff <= 13'h0000;
    end else if (wend) begin
      hold_ff <= max_w;                    // [RULE8]
    end
  end
  // ************************************************************
  // Buffer and link serializer
  // ************************************************************
  logic        push_v;
  logic        fifo_ov;
  logic        load;
  logic [12:0] fifo_od;
  logic        link_en;
  logic [23:0] sh_ff;                      // Bits still to send after current
  logic [4:0]  cnt_ff;                     // Bits remaining in frame
  logic [2:0]  cbits_ff;                   // Control bits of current sample
  logic [FRAME_LEN-1:0] frame_w;           // Frame of the peak at the buffer head
  function automatic logic [FRAME_LEN-1:0] build_frame(input logic [12:0] p);
    build_frame = {ID_SUBFR, 1'b0, p[12:9], 1'b0, p[8:5], 1'b0, p[4:1],
                   1'b0, p[0], PAD_ZEROS};                           // [RULE18]
  endfunction
  assign frame_w = build_frame(fifo_od);   // [RULE18]
  // A full buffer drops the newest window result; the holding register still updates
  assign push_v  = wend && link_en;
  assign link_en = ((lena_ff[1:0] & LENA_MASK) == LENA_MASK) && lenb_ff[LENB_BIT]; // [RULE12]
  assign load    = link_sample_strobe && link_en && (cnt_ff == 5'h00) && fifo_ov;
  apsm_fifo #(
    .WIDTH (13),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push_v),
    .in_ready  (peak_fifo_ready),
    .in_data   (max_w),
    .out_valid (fifo_ov),
    .out_ready (load),
    .out_data  (fifo_od)
  );

  // Serializer: one bit per link sample, MSB first, idle ones while the buffer is empty [RULE16]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_ff    <= 24'h000000;
      cnt_ff   <= 5'h00;
      cbits_ff <= 3'h0;
    end else if (!link_en) begin
      cnt_ff   <= 5'h00;
      cbits_ff <= 3'h0;                    // [RULE12]
    end else if (link_sample_strobe) begin
      if (load) begin
        cbits_ff <= {frame_w[FRAME_LEN-1], 2'h0};                    // [RULE14]
        sh_ff    <= frame_w[FRAME_LEN-2:0];
        cnt_ff   <= FRAME_CNT;             // [RULE16]
      end else if (cnt_ff != 5'h00) begin
        cbits_ff <= {sh_ff[23], 2'h0};     // [RULE13]
        sh_ff    <= {sh_ff[22:0], 1'b0};
        cnt_ff   <= cnt_ff - 5'h01;
      end else begin
        cbits_ff <= 3'h4;                  // Idle one in MSB position [RULE18]
      end
    end
  end
  assign link_ctrl_bits = cbits_ff;        // Receiver reassembles [RULE17]

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_mag;
    !sample_in[SAMPLE_W-1] && (sample_in <= SAMPLE_W'(MAG_MAX)) |-> mag_w == sample_in[12:0];
  endproperty
  a_mag: assert property (p_mag) else $error("magnitude wrong"); // [RULE1]
  property p_count;
    en && en_d_ff && timer_ff > 24'h000001 ##1 en |-> timer_ff == $past(timer_ff) - 24'h000001;
  endproperty
  a_count: assert property (p_count) else $error("timer not counting"); // [RULE5]
  property p_hold;
    wend |=> hold_ff == $past(max_w);
  endproperty
  a_hold: assert property (p_hold) else $error("holding not captured"); // [RULE8]
  property p_reload;
    wend |=> timer_ff == $past(win_eff) && first_ff;
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded"); // [RULE9]
  property p_seed;
    en && en_d_ff && first_ff ##1 en |-> peak_ff == $past(mag_w);
  endproperty
  a_seed: assert property (p_seed) else $error("peak not seeded"); // [RULE10]
  property p_start;
    $rose(en) |=> first_ff;
  endproperty
  a_start: assert property (p_start) else $error("start not seeded"); // [RULE7]
  property p_grow;
    en && en_d_ff && !first_ff && !wend |=> peak_ff >= $past(peak_ff);
  endproperty
  a_grow: assert property (p_grow) else $error("peak dropped"); // [RULE6]
  property p_off;
    !link_en |=> link_ctrl_bits == 3'h0;
  endproperty
  a_off: assert property (p_off) else $error("side channel active"); // [RULE12]
  property p_lsb;
    link_ctrl_bits[1:0] == 2'h0;
  endproperty
  a_lsb: assert property (p_lsb) else $error("low control bits used"); // [RULE14]
  property p_frame;
    load |=> cnt_ff == FRAME_CNT && link_ctrl_bits == 3'h0;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start wrong"); // [RULE16]
  c_window: cover property (wend ##1 wend);
  c_load:   cover property (load);
  c_full:   cover property (!peak_fifo_ready);
endmodule

// ===== design/apsm_pkg.sv
// Package of register map, field positions, reset values and frame layout for the peak monitor
package apsm_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h270;  // Monitor control
  localparam logic [11:0] ADDR_WIN0   = 12'h271;  // Window length bits 7:0
  localparam logic [11:0] ADDR_WIN1   = 12'h272;  // Window length bits 15:8
  localparam logic [11:0] ADDR_WIN2   = 12'h273;  // Window length bits 23:16
  localparam logic [11:0] ADDR_PEAK0  = 12'h274;  // Peak holding bits 7:0
  localparam logic [11:0] ADDR_PEAK1  = 12'h275;  // Peak holding bits 12:8
  localparam logic [11:0] ADDR_LENA   = 12'h279;  // Link enable a
  localparam logic [11:0] ADDR_LENB   = 12'h27a;  // Link enable b
  localparam logic [11:0] ADDR_SELA   = 12'h559;  // Control bit select a
  localparam logic [11:0] ADDR_SELB   = 12'h55a;  // Control bit select b
  localparam logic [11:0] ADDR_CSPS   = 12'h58f;  // Control bits per sample
  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int          CTRL_PEAK_EN_BIT = 1;         // Peak detect enable
  localparam logic [1:0]  LENA_MASK        = 2'h3;      // Bits 1:0 of link enable a
  localparam int          LENB_BIT         = 1;         // Bit 1 of link enable b
  localparam logic [7:0]  RST_BYTE         = 8'h00;     // Reset of byte registers
  localparam logic [23:0] RST_WIN          = 24'h000000; // Reset of window length
  localparam logic [12:0] MAG_MAX          = 13'h1fff;  // Largest 13-bit magnitude
  // ************************************************************
  // Side channel frame
  // ************************************************************
  localparam int          FRAME_LEN  = 25;              // Bits per frame
  localparam logic [4:0]  FRAME_CNT  = 5'h18;           // Bits left after the first
  localparam logic [4:0]  ID_SUBFR   = 5'h01;           // Start 0 then identifier 0001
  localparam logic [2:0]  PAD_ZEROS  = 3'h0;            // Padding after peak bit 0
  localparam int          FIFO_DEPTH = 32;              // Peak values buffered
endpackage

// ===== sim/apsm_link_rx.sv
// Link receiver model: paces sample strobes and rebuilds monitor frames
`timescale 1ns/1ns
module apsm_link_rx (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  gap,
  input  wire logic [2:0]  link_ctrl_bits,
  output logic             link_sample_strobe,
  output logic             frame_done,
  output logic [12:0]      frame_peak,
  output logic             frame_bad
);
  // ************************************************************
  // Strobe pacing and frame assembly
  // ************************************************************
  logic [3:0]  gap_cnt_ff;                   // Cycles since last strobe
  logic        took_ff;                      // Strobe taken last edge
  logic        low_ff;                       // Unused control bits seen high
  logic        armed_ff;                     // Idle one seen, zeros now open frames
  logic [24:0] shift_ff;                     // Frame bits so far
  logic [4:0]  bit_cnt_ff;                   // Bits of frame so far
  logic [24:0] full;                         // Frame including newest bit
  logic        bit_now;                      // Monitor control bit
  assign bit_now = link_ctrl_bits[2];        // Top control bit
  assign full    = {shift_ff[23:0], bit_now};
  // A nonzero gap makes the transmitter look slow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_ff         <= 4'h0;
      link_sample_strobe <= 1'b0;
      took_ff            <= 1'b0;
    end else begin
      took_ff            <= link_sample_strobe;
      link_sample_strobe <= (gap_cnt_ff >= gap);
      gap_cnt_ff         <= (gap_cnt_ff >= gap) ? 4'h0 : gap_cnt_ff + 4'h1;
    end
  end
  // Ones are idle; a zero opens a frame, start bits checked at its end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff   <= 25'h0;
      bit_cnt_ff <= 5'h0;
      low_ff     <= 1'b0;
      armed_ff   <= 1'b0;
      frame_done <= 1'b0;
      frame_peak <= 13'h0;
      frame_bad  <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (took_ff && link_ctrl_bits[1:0] != 2'h0) begin
        low_ff <= 1'b1;
      end
      if (took_ff && bit_cnt_ff == 5'h0) begin
        // A disabled channel shows zeros, so only trust a start bit after an idle one
        if (bit_now) begin
          armed_ff <= 1'b1;
        end else if (armed_ff) begin         // Start of frame
          shift_ff   <= 25'h0;
          bit_cnt_ff <= 5'h1;
        end
      end else if (took_ff) begin
        shift_ff   <= full;
        bit_cnt_ff <= (bit_cnt_ff == 5'h18) ? 5'h0 : bit_cnt_ff + 5'h1;
        if (bit_cnt_ff == 5'h18) begin       // Last bit: validate
          frame_done <= 1'b1;
          frame_peak <= {full[18:15], full[13:10], full[8:5], full[3]};
          frame_bad  <= (full[24:20] != 5'h01) | full[19] | full[14] | full[9]
                        | full[4] | (full[2:0] != 3'h0) | low_ff;
        end
      end
    end
  end
endmodule

// ===== sim/apsm_monitor_tb.sv
// Testbench of the peak monitor with a link receiver model
`timescale 1ns/1ns
module apsm_monitor_tb
  import apsm_pkg::*;
;
  logic        clk, arst_n, reg_wr, reg_rd, reg_rvalid, strobe;
  logic        fifo_ready, f_done, f_bad;
  logic [13:0] sample_in;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [2:0]  ctrl_bits;
  logic [12:0] holding, f_peak;
  logic [12:0] q_exp[$];                     // Peaks expected on the link
  logic [3:0]  rx_gap;
  int          err_count, comparisons, rx_count, k;
  // Read-write registers first, peak bytes last
  logic [11:0] all_addr [11] = '{ADDR_CTRL, ADDR_WIN0, ADDR_WIN1, ADDR_WIN2, ADDR_LENA,
                                 ADDR_LENB, ADDR_SELA, ADDR_SELB, ADDR_CSPS, ADDR_PEAK0,
                                 ADDR_PEAK1};
  apsm_monitor #(.SAMPLE_W(14)) DUT (
    .clk(clk), .arst_n(arst_n), .sample_in(sample_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .link_sample_strobe(strobe), .link_ctrl_bits(ctrl_bits),
    .peak_fifo_ready(fifo_ready), .peak_holding(holding));
  apsm_link_rx RX (
    .clk(clk), .arst_n(arst_n), .gap(rx_gap), .link_ctrl_bits(ctrl_bits),
    .link_sample_strobe(strobe), .frame_done(f_done), .frame_peak(f_peak), .frame_bad(f_bad));
  always #25 clk = ~clk;
  // ************************************************************
  // Compare, bus and reference helpers
  // ************************************************************
  task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_peak(input string n, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_flag(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  // Strobes rise on a clock edge and fall on the taking edge
  task automatic reg_write(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp_flag("reg_rvalid", 1'b1, reg_rvalid);
    cmp_reg($sformatf("register %h", a), e, reg_rdata);
  endtask
  // Most negative sample has no 13-bit magnitude, so it saturates
  function automatic logic [12:0] mag(input logic [13:0] s);
    logic [13:0] n;
    n = -s;
    if (s == 14'h2000) return MAG_MAX;
    return s[13] ? n[12:0] : s[12:0];
  endfunction
  // Odd windows stay small so a peak left from the last window shows
  task automatic run_windows(input logic [23:0] n, input int nwin, input int npush);
    logic [12:0] pk;
    logic [13:0] s;
    pk = 13'h0;
    reg_write(ADDR_WIN0, n[7:0]);            // Window set first
    reg_write(ADDR_WIN1, n[15:8]);
    reg_write(ADDR_WIN2, n[23:16]);
    reg_write(ADDR_CTRL, 8'h02);
    @(posedge clk);
    for (int w = 0; w < nwin; w++) begin
      for (int i = 0; i < n; i++) begin
        s = 14'($urandom);
        if (w[0]) s = {{6{s[13]}}, s[7:0]};
        if (w == 0 && i == n - 1) s = 14'h2000;
        sample_in <= s;
        pk = (i == 0 || mag(s) > pk) ? mag(s) : pk;
        @(posedge clk);
      end
      #1;
      cmp_peak("peak_holding", pk, holding);
      if (w < npush) q_exp.push_back(pk);
    end
    reg_write(ADDR_CTRL, 8'h00);
    repeat (10) begin
      sample_in <= 14'($urandom);
      @(posedge clk);
    end
    cmp_peak("peak_holding kept", pk, holding);
    reg_check(ADDR_PEAK0, pk[7:0]);
    reg_check(ADDR_PEAK1, {3'h0, pk[12:8]});
  endtask
  // Every rebuilt frame must match the next expected peak
  always @(posedge clk) begin
    if (f_done === 1'b1) begin
      rx_count++;
      cmp_flag("frame_bad", 1'b0, f_bad);
      cmp_flag("frame expected", 1'b1, q_exp.size() > 0);
      if (q_exp.size() > 0) cmp_peak("frame peak", q_exp.pop_front(), f_peak);
    end
  end
  task automatic final_report();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog: the run needs about 1800 cycles
  initial begin
    #(8000 * 50);
    err_count++;
    final_report();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    sample_in = 14'h0000;
    rx_gap = 4'h0;
    void'($urandom(32'h26dc2c3c));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp_peak("peak_holding reset", 13'h0, holding);
    cmp_flag("peak_fifo_ready reset", 1'b1, fifo_ready);
    for (k = 0; k < 11; k++) reg_check(all_addr[k], RST_BYTE);
    reg_check(12'h123, 8'h00);               // Unmapped reads zero
    reg_write(ADDR_PEAK0, 8'hff);
    reg_check(ADDR_PEAK0, 8'h00);            // Read-only holding
    for (k = 0; k < 9; k++) begin
      d = 8'($urandom);
      if (k == 0) d[CTRL_PEAK_EN_BIT] = 1'b0;
      if (all_addr[k] == ADDR_LENB) d[LENB_BIT] = 1'b0;  // Link stays off until frames are due
      reg_write(all_addr[k], d);
      reg_check(all_addr[k], d);
    end
    $display("TEST registers done");
    reg_write(ADDR_LENA, 8'h01);             // Link only half enabled
    reg_write(ADDR_LENB, 8'h02);
    run_windows(24'd1, 20, 0);
    run_windows(24'd7, 6, 0);
    cmp_reg("link_ctrl_bits off", 8'h00, {5'h0, ctrl_bits});
    cmp_reg("frames while off", 8'h00, 8'(rx_count));
    $display("TEST short windows done");
    reg_write(ADDR_SELA, 8'h01);             // Route monitor onto link
    reg_write(ADDR_SELB, 8'h01);
    reg_write(ADDR_CSPS, 8'h01);
    reg_write(ADDR_LENA, 8'h03);
    repeat (4) @(posedge clk);
    #1;
    cmp_reg("link_ctrl_bits idle", 8'h04, {5'h0, ctrl_bits});
    run_windows(24'd40, 4, 4);
    repeat (60) @(posedge clk);
    cmp_reg("frames left", 8'h00, 8'(q_exp.size()));
    $display("TEST link frames done");
    rx_gap <= 4'hf;
    run_windows(24'd3, 100, 33);
    cmp_flag("peak_fifo_ready full", 1'b0, fifo_ready);
    rx_gap <= 4'h0;
    repeat (1000) @(posedge clk);
    cmp_flag("peak_fifo_ready drained", 1'b1, fifo_ready);
    cmp_reg("frames left", 8'h00, 8'(q_exp.size()));
    cmp_reg("frames total", 8'd37, 8'(rx_count));
    $display("TEST buffer fill done");
    final_report();
  end
endmodule
